// ==== mixer_ctrl_consts.svh ====
`ifndef MIXER_CTRL_CONSTS_SVH
`define MIXER_CTRL_CONSTS_SVH

// delays in pixel clock cycles
`define PASS_DLY 14
`define AUX_DLY 14
`define AV_LONG_DLY 14
`define AV_SHORT_DLY 12
`define CONV_LONG_DLY 15
`define CONV_SHORT_DLY 2
`define PIX_LAT 14
`define CFG_SETTLE 5'h10

// host register indices
`define REG_CTRL0 3'h0
`define REG_CTRL1 3'h1
`define REG_CTRL2 3'h2
`define REG_TAB_PTR 3'h3
`define REG_COLOUR_TAB 3'h4
`define REG_ALPHA_TAB 3'h5
`define REG_STATUS 3'h6

// ctrl0 field positions and status drop bit
`define CTRL0_YCC 0
`define CTRL0_TWOS 1
`define CTRL0_422 2
`define CTRL0_AV_SHORT 3
`define CTRL0_CONV_DLY 4
`define STATUS_DROP 7

// reset values
`define CTRL0_RST 8'h00
`define CTRLX_RST 8'h00

// blanking levels
`define LUMA_BLACK 8'h10
`define CHROMA_OFFSET_ZERO 8'h80
`define CHROMA_TWOS_ZERO 8'h00

// table write buffer
`define WBUF_DEPTH 8

`endif

// ==== mixer_ctrl_pkg.sv ====
`default_nettype none

package mixer_ctrl_pkg;

   typedef struct packed {
      logic cs_n;
      logic rw;
      logic [2:0] addr;
      logic [7:0] data;
   } host_pins_s;

   typedef struct packed {
      logic [23:0] data;
      logic cb;
   } pix_s;

   typedef struct packed {
      logic alpha;
      logic [7:0] addr;
      logic [7:0] data;
   } tab_wr_s;

   typedef enum logic [1:0] {
      HOST_IDLE,
      HOST_READ,
      HOST_WRITE
   } host_state_e;

endpackage

`default_nettype wire

// ==== sync_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none

module sync_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] count
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // handshakes on both sides
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign count = cnt_q;

   // storage
   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers and level
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

endmodule

`default_nettype wire

// ==== mixer_ctrl_delay.sv ====
// Overview of operation
// R1: pass selected port only while pass enabled
// R2: auxiliary signal out delayed 14 cycles
// R3: pass enable out delayed 14 cycles
// R4: active video accepts both pixel ports
// R5: no active video, GBR output zero
// R6: no active video, YCbCr black levels
// R7: 4:2:2 first pixel after rise is Cb
// R8: active video out delayed 12 or 14
// R9: sync enable drives sync current
// R10: sync delayed 2 or 15 cycles
// R11: blanking enables data and pedestal currents
// R12: blanking delayed 2 or 15 cycles
// R13: read/write level picks access direction
// R14: direction latched at chip select fall
// R15: data port driven only during reads
// R16: write data captured at chip select rise
// R17: host idles 4 cycles between table accesses
// R18: address latched at chip select fall
// R19: one 8-bit port reaches all registers
// R20: pixel output latency 14 cycles
// R21: active video delay selectable, default 14
// R22: control inputs registered on clock edge
`timescale 1ns/10ps
`default_nettype none
`include "mixer_ctrl_consts.svh"

module mixer_ctrl_delay (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic pass_gate_in,
   input wire logic pass_source_select,
   input wire logic aux_signal_in,
   input wire logic active_video_in,
   input wire logic sync_in,
   input wire logic blank_in,
   input wire logic [23:0] a_pixel_port,
   input wire logic [23:0] b_pixel_port,
   input wire logic cs_n_in,
   input wire logic rw_in,
   input wire logic [2:0] host_reg_select,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   output logic pass_gate_delayed_out,
   output logic aux_signal_delayed_out,
   output logic delayed_active_video_out,
   output logic sync_current_en,
   output logic blank_current_en,
   output logic [23:0] mixed_pixel_out,
   output logic chroma_cb_out
);

   logic [14:0] pass_sh_q;
   logic [14:0] aux_sh_q;
   logic [14:0] av_sh_q;
   logic [14:0] sync_sh_q;
   logic [14:0] blank_sh_q;
   logic [23:0] a_q;
   logic [23:0] b_q;
   logic sel_q;
   logic cb_last_q;
   mixer_ctrl_pkg::pix_s pix_q [12];
   mixer_ctrl_pkg::pix_s pix_d;
   logic [7:0] ctrl0_q;
   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic [7:0] ptr_q;
   logic drop_q;
   logic [7:0] colour_tab [256];
   logic [7:0] alpha_tab [256];
   mixer_ctrl_pkg::host_pins_s pins_m_q;
   mixer_ctrl_pkg::host_pins_s pins_s_q;
   logic cs_p_q;
   logic cs_fall;
   logic cs_rise;
   logic rw_lat_q;
   logic [2:0] addr_lat_q;
   mixer_ctrl_pkg::host_state_e state_q;
   mixer_ctrl_pkg::tab_wr_s wb_in;
   mixer_ctrl_pkg::tab_wr_s wb_out;
   logic wb_push;
   logic wb_ready;
   logic wb_valid;
   logic wb_pop;
   logic [3:0] wb_count;
   logic tab_access;
   logic [7:0] rd_mux;

   ////////////////////////////////////////////////////////////////////
   // helpers

   // per-component half mix of two words
   function automatic logic [23:0] mix24(input logic [23:0] a, input logic [23:0] b);
      logic [8:0] s;
      logic [23:0] r;
      r = '0;
      for (int i = 0; i < 3; i++)
      begin
         s = {1'b0, a[i*8 +: 8]} + {1'b0, b[i*8 +: 8]};
         r[i*8 +: 8] = s[8:1];
      end
      return r;
   endfunction

   // black word for the current output format
   function automatic logic [23:0] black24(input logic ycc, input logic twos);
      logic [7:0] c;
      c = twos ? `CHROMA_TWOS_ZERO : `CHROMA_OFFSET_ZERO;
      return ycc ? {`LUMA_BLACK, c, c} : 24'h00_0000;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // control delay lines, stage 0 is the input register

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pass_sh_q <= '0;
         aux_sh_q <= '0;
         av_sh_q <= '0;
         sync_sh_q <= '0;
         blank_sh_q <= '0;
      end
      else
      begin
         pass_sh_q <= {pass_sh_q[13:0], pass_gate_in}; // R22
         aux_sh_q <= {aux_sh_q[13:0], aux_signal_in}; // R22
         av_sh_q <= {av_sh_q[13:0], active_video_in}; // R22
         sync_sh_q <= {sync_sh_q[13:0], sync_in}; // R22
         blank_sh_q <= {blank_sh_q[13:0], blank_in}; // R22
      end
   end

   // delayed control outputs
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pass_gate_delayed_out <= 1'b0;
         aux_signal_delayed_out <= 1'b0;
         delayed_active_video_out <= 1'b0;
         sync_current_en <= 1'b0;
         blank_current_en <= 1'b0;
      end
      else
      begin
         pass_gate_delayed_out <= pass_sh_q[`PASS_DLY-2]; // R3
         aux_signal_delayed_out <= aux_sh_q[`AUX_DLY-2]; // R2
         delayed_active_video_out <= ctrl0_q[`CTRL0_AV_SHORT] ?
            av_sh_q[`AV_SHORT_DLY-2] : av_sh_q[`AV_LONG_DLY-2]; // R8 R21
         // low turns the current source off
         sync_current_en <= ctrl0_q[`CTRL0_CONV_DLY] ?
            sync_sh_q[`CONV_LONG_DLY-2] : sync_sh_q[`CONV_SHORT_DLY-2]; // R9 R10
         blank_current_en <= ctrl0_q[`CTRL0_CONV_DLY] ?
            blank_sh_q[`CONV_LONG_DLY-2] : blank_sh_q[`CONV_SHORT_DLY-2]; // R11 R12
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pixel path

   // pixel input registers
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         a_q <= '0;
         b_q <= '0;
         sel_q <= 1'b0;
      end
      else
      begin
         a_q <= a_pixel_port; // R4
         b_q <= b_pixel_port; // R4
         sel_q <= pass_source_select;
      end
   end

   // first stage: pass, mix or black, and chroma phase
   always_comb
   begin
      pix_d.cb = 1'b0;
      if (!av_sh_q[0])
      begin
         pix_d.data = black24(ctrl0_q[`CTRL0_YCC], ctrl0_q[`CTRL0_TWOS]); // R5 R6
      end
      else if (pass_sh_q[0])
      begin
         pix_d.data = sel_q ? b_q : a_q; // R1
      end
      else
      begin
         pix_d.data = mix24(a_q, b_q); // R4
      end
      if (ctrl0_q[`CTRL0_422] && av_sh_q[0])
      begin
         pix_d.cb = !av_sh_q[1] ? 1'b1 : !cb_last_q; // R7
      end
   end

   // chroma phase memory
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cb_last_q <= 1'b0;
      end
      else
      begin
         cb_last_q <= pix_d.cb;
      end
   end

   // remaining pipeline stages
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < 12; i++)
         begin
            pix_q[i] <= '0;
         end
         mixed_pixel_out <= '0;
         chroma_cb_out <= 1'b0;
      end
      else
      begin
         pix_q[0] <= pix_d;
         for (int i = 1; i < 12; i++)
         begin
            pix_q[i] <= pix_q[i-1];
         end
         mixed_pixel_out <= pix_q[`PIX_LAT-3].data; // R20
         chroma_cb_out <= pix_q[`PIX_LAT-3].cb;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // host port

   // pin synchroniser
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pins_m_q <= '{cs_n: 1'b1, default: '0};
         pins_s_q <= '{cs_n: 1'b1, default: '0};
         cs_p_q <= 1'b1;
      end
      else
      begin
         pins_m_q <= '{cs_n_in, rw_in, host_reg_select, host_data_in};
         pins_s_q <= pins_m_q;
         cs_p_q <= pins_s_q.cs_n;
      end
   end

   assign cs_fall = cs_p_q && !pins_s_q.cs_n;
   assign cs_rise = !cs_p_q && pins_s_q.cs_n;
   assign tab_access = (addr_lat_q == `REG_COLOUR_TAB) || (addr_lat_q == `REG_ALPHA_TAB);

   // read data selection
   always_comb
   begin
      case (pins_s_q.addr)
         `REG_CTRL0: rd_mux = ctrl0_q;
         `REG_CTRL1: rd_mux = ctrl1_q;
         `REG_CTRL2: rd_mux = ctrl2_q;
         `REG_TAB_PTR: rd_mux = ptr_q;
         `REG_COLOUR_TAB: rd_mux = colour_tab[ptr_q];
         `REG_ALPHA_TAB: rd_mux = alpha_tab[ptr_q];
         `REG_STATUS: rd_mux = {drop_q, !wb_ready, 2'b00, wb_count};
         default: rd_mux = 8'h00;
      endcase
   end

   // access sequencer
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state_q <= mixer_ctrl_pkg::HOST_IDLE;
         rw_lat_q <= 1'b1;
         addr_lat_q <= '0;
         host_data_out <= '0;
         host_data_oe <= 1'b0;
      end
      else
      begin
         case (state_q)
            mixer_ctrl_pkg::HOST_IDLE:
            begin
               if (cs_fall)
               begin
                  rw_lat_q <= pins_s_q.rw; // R14 R13
                  addr_lat_q <= pins_s_q.addr; // R18
                  host_data_out <= rd_mux; // R19
                  host_data_oe <= pins_s_q.rw; // R15
                  state_q <= pins_s_q.rw ? mixer_ctrl_pkg::HOST_READ :
                     mixer_ctrl_pkg::HOST_WRITE;
               end
            end
            mixer_ctrl_pkg::HOST_READ, mixer_ctrl_pkg::HOST_WRITE:
            begin
               if (cs_rise)
               begin
                  host_data_oe <= 1'b0; // R15
                  state_q <= mixer_ctrl_pkg::HOST_IDLE;
               end
            end
            default:
            begin
               host_data_oe <= 1'b0;
               state_q <= mixer_ctrl_pkg::HOST_IDLE;
            end
         endcase
      end
   end

   // control registers, pointer and drop flag
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         ctrl0_q <= `CTRL0_RST;
         ctrl1_q <= `CTRLX_RST;
         ctrl2_q <= `CTRLX_RST;
         ptr_q <= '0;
         drop_q <= 1'b0;
      end
      else
      begin
         if (cs_rise && state_q == mixer_ctrl_pkg::HOST_WRITE)
         begin
            case (addr_lat_q) // R16
               `REG_CTRL0: ctrl0_q <= pins_s_q.data;
               `REG_CTRL1: ctrl1_q <= pins_s_q.data;
               `REG_CTRL2: ctrl2_q <= pins_s_q.data;
               `REG_TAB_PTR: ptr_q <= pins_s_q.data;
               default: ;
            endcase
         end
         // table accesses step the pointer
         if (cs_rise && state_q != mixer_ctrl_pkg::HOST_IDLE && tab_access)
         begin
            ptr_q <= ptr_q + 8'h01;
         end
         // set wins over a clear by writing one
         if (wb_push && !wb_ready)
         begin
            drop_q <= 1'b1;
         end
         else if (cs_rise && state_q == mixer_ctrl_pkg::HOST_WRITE &&
            addr_lat_q == `REG_STATUS && pins_s_q.data[`STATUS_DROP])
         begin
            drop_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // table writes buffered, applied outside active video

   assign wb_push = cs_rise && state_q == mixer_ctrl_pkg::HOST_WRITE && tab_access; // R16
   assign wb_in = '{addr_lat_q == `REG_ALPHA_TAB, ptr_q, pins_s_q.data};
   assign wb_pop = wb_valid && !av_sh_q[0];

   sync_fifo #(
      .WIDTH($bits(mixer_ctrl_pkg::tab_wr_s)),
      .DEPTH(`WBUF_DEPTH)
   ) u_wbuf (
      .ref_clk(ref_clk),
      .srst(srst),
      .in_valid(wb_push),
      .in_ready(wb_ready),
      .in_data(wb_in),
      .out_valid(wb_valid),
      .out_ready(!av_sh_q[0]),
      .out_data(wb_out),
      .count(wb_count)
   );

   // table storage
   always_ff @(posedge ref_clk)
   begin
      if (wb_pop)
      begin
         if (wb_out.alpha)
         begin
            alpha_tab[wb_out.addr] <= wb_out.data;
         end
         else
         begin
            colour_tab[wb_out.addr] <= wb_out.data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   logic [4:0] warm_q;
   logic [4:0] cfg_age_q;
   logic ok;

   // cycles since reset and since last ctrl0 write
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         warm_q <= '0;
         cfg_age_q <= '0;
      end
      else
      begin
         warm_q <= (warm_q == `CFG_SETTLE) ? warm_q : warm_q + 5'h01;
         if (cs_rise && state_q == mixer_ctrl_pkg::HOST_WRITE && addr_lat_q == `REG_CTRL0)
            cfg_age_q <= '0;
         else if (cfg_age_q != `CFG_SETTLE)
            cfg_age_q <= cfg_age_q + 5'h01;
      end
   end

   assign ok = (warm_q == `CFG_SETTLE) && (cfg_age_q == `CFG_SETTLE);

   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_read_start;
      cs_fall && pins_s_q.rw && state_q == mixer_ctrl_pkg::HOST_IDLE;
   endsequence
   sequence s_ctrl0_write;
      cs_rise && state_q == mixer_ctrl_pkg::HOST_WRITE && addr_lat_q == `REG_CTRL0;
   endsequence

   AST_PASS_GATE: assert property (ok |-> pass_gate_delayed_out == $past(pass_gate_in, 14)) // R3
      else $error("pass enable delay wrong");
   AST_AUX: assert property (ok |-> aux_signal_delayed_out == $past(aux_signal_in, 14)) // R2
      else $error("aux signal delay wrong");
   AST_AV_LONG: assert property (ok && !ctrl0_q[`CTRL0_AV_SHORT] |->
      delayed_active_video_out == $past(active_video_in, 14)) // R8
      else $error("active video long delay wrong");
   AST_AV_SHORT: assert property (ok && ctrl0_q[`CTRL0_AV_SHORT] |->
      delayed_active_video_out == $past(active_video_in, 12)) // R21
      else $error("active video short delay wrong");
   AST_SYNC: assert property (ok |-> sync_current_en == (ctrl0_q[`CTRL0_CONV_DLY] ?
      $past(sync_in, 15) : $past(sync_in, 2))) // R10
      else $error("sync delay wrong");
   AST_BLANK: assert property (ok |-> blank_current_en == (ctrl0_q[`CTRL0_CONV_DLY] ?
      $past(blank_in, 15) : $past(blank_in, 2))) // R12
      else $error("blank delay wrong");
   AST_BLACK: assert property (ok && !$past(active_video_in, 14) |->
      mixed_pixel_out == black24(ctrl0_q[`CTRL0_YCC], ctrl0_q[`CTRL0_TWOS])) // R5
      else $error("black level wrong");
   AST_PASS_DATA: assert property (ok && $past(active_video_in, 14) && $past(pass_gate_in, 14)
      |-> mixed_pixel_out == ($past(pass_source_select, 14) ?
      $past(b_pixel_port, 14) : $past(a_pixel_port, 14))) // R1
      else $error("pass data wrong");
   AST_READ_DRIVE: assert property (s_read_start |=> host_data_oe) // R15
      else $error("read data not driven");
   AST_IDLE_FLOAT: assert property (state_q == mixer_ctrl_pkg::HOST_IDLE |-> !host_data_oe) // R15
      else $error("data port driven while idle");
   AST_RW_HOLD: assert property (state_q != mixer_ctrl_pkg::HOST_IDLE && !cs_rise
      |=> $stable(rw_lat_q) && $stable(addr_lat_q)) // R14
      else $error("direction changed in access");
   AST_CTRL_WRITE: assert property (s_ctrl0_write |=> ctrl0_q == $past(pins_s_q.data)) // R16
      else $error("control write lost");

endmodule

`default_nettype wire

// ==== mixer_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////
// host bus side of the parallel register port
module mixer_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe,
   output var mixer_ctrl_pkg::host_pins_s pins
);
   logic cs_n_q = 1'b1;
   logic rw_q = 1'b1;
   logic [2:0] addr_q = 3'h0;
   logic [7:0] wdat_q = 8'h00;
   logic drv_q = 1'b0;
   logic [7:0] last_q = 8'h00;

   // data wire: device, else host, else inverse of last level
   assign pins = '{cs_n: cs_n_q, rw: rw_q, addr: addr_q,
      data: host_data_oe ? host_data_out : (drv_q ? wdat_q : ~last_q)};

   // remember the last wire level
   always @(posedge ref_clk)
      last_q <= pins.data;

   // one access: low phase, data hold, then idle high phase
   task automatic access(input logic rw, input logic [2:0] a, input logic [7:0] wd,
      output logic [7:0] rd, output logic oe);
      @(posedge ref_clk);
      cs_n_q <= 1'b0;
      rw_q <= rw;
      addr_q <= a;
      wdat_q <= wd;
      drv_q <= ~rw;
      repeat (6) @(posedge ref_clk);
      rd = pins.data;
      oe = host_data_oe;
      cs_n_q <= 1'b1;
      repeat (6) @(posedge ref_clk);
      drv_q <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
endmodule

`default_nettype wire

// ==== mixer_ctrl_delay_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module mixer_ctrl_delay_tb_top;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic pass_gate_in = 1'b0;
   logic pass_source_select = 1'b0;
   logic aux_signal_in = 1'b0;
   logic active_video_in = 1'b0;
   logic sync_in = 1'b0;
   logic blank_in = 1'b0;
   logic [23:0] a_pixel_port = 24'h00_0000;
   logic [23:0] b_pixel_port = 24'h00_0000;
   logic [7:0] host_data_out;
   logic host_data_oe;
   logic pass_gate_delayed_out;
   logic aux_signal_delayed_out;
   logic delayed_active_video_out;
   logic sync_current_en;
   logic blank_current_en;
   logic [23:0] mixed_pixel_out;
   logic chroma_cb_out;
   mixer_ctrl_pkg::host_pins_s pins;
   logic [7:0] cnt = 8'h00;
   logic av_force = 1'b0;
   logic chk_en = 1'b0;
   logic [7:0] cfg_q = 8'h00;
   int av_n = 14;
   int conv_n = 2;
   logic [15:0] h_pass, h_aux, h_av, h_sync, h_blank, h_cb;
   logic [23:0] h_px [0:15];
   logic ph = 1'b0;
   logic [7:0] rd;
   logic oe;
   int err_count = 0;
   int num_checks = 0;

   mixer_ctrl_delay u_mixer_ctrl_delay (.ref_clk(ref_clk), .srst(srst),
      .pass_gate_in(pass_gate_in), .pass_source_select(pass_source_select),
      .aux_signal_in(aux_signal_in), .active_video_in(active_video_in),
      .sync_in(sync_in), .blank_in(blank_in), .a_pixel_port(a_pixel_port),
      .b_pixel_port(b_pixel_port), .cs_n_in(pins.cs_n), .rw_in(pins.rw),
      .host_reg_select(pins.addr), .host_data_in(pins.data),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe),
      .pass_gate_delayed_out(pass_gate_delayed_out),
      .aux_signal_delayed_out(aux_signal_delayed_out),
      .delayed_active_video_out(delayed_active_video_out),
      .sync_current_en(sync_current_en), .blank_current_en(blank_current_en),
      .mixed_pixel_out(mixed_pixel_out), .chroma_cb_out(chroma_cb_out));

   mixer_host_model u_mixer_host_model (.ref_clk(ref_clk),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe), .pins(pins));

   ////////////////////////////////////////////////////////////
   // clock
   always #25 ref_clk = ~ref_clk;

   // video stream pattern, av held high on request
   always @(posedge ref_clk)
   begin
      cnt <= cnt + 8'h01;
      pass_gate_in <= cnt[2];
      pass_source_select <= cnt[4];
      aux_signal_in <= cnt[0] ^ cnt[3];
      active_video_in <= av_force | (cnt[5:3] != 3'h0);
      sync_in <= cnt[1];
      blank_in <= cnt[0] ^ cnt[2];
      a_pixel_port <= {cnt, ~cnt, cnt ^ 8'h5A};
      b_pixel_port <= {~cnt, cnt + 8'h33, cnt};
   end

   ////////////////////////////////////////////////////////////
   // mismatch reporting
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (!ok)
      begin
         err_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   // expected mixer word for one input sample
   function automatic logic [23:0] exp_pix(input logic av, input logic ps, input logic sel,
      input logic [23:0] a, input logic [23:0] b);
      logic [23:0] m;
      logic [8:0] s;
      m = 24'h00_0000;
      if (!av)
         m = cfg_q[0] ? (cfg_q[1] ? 24'h10_0000 : 24'h10_8080) : 24'h00_0000;
      else if (ps)
         m = sel ? b : a;
      else
         for (int i = 0; i < 3; i++)
         begin
            s = a[i*8+:8] + b[i*8+:8];
            m[i*8+:8] = s[8:1];
         end
      return m;
   endfunction

   // input history and per-cycle comparison of delayed outputs, pixel word outside 4:2:2, Cb phase only in 4:2:2 active video
   always @(posedge ref_clk)
   begin
      ph = active_video_in ? (h_av[0] ? ~ph : 1'b1) : 1'b0;
      for (int i = 15; i > 0; i--)
         h_px[i] = h_px[i-1];
      h_px[0] = exp_pix(active_video_in, pass_gate_in, pass_source_select,
         a_pixel_port, b_pixel_port);
      h_pass = {h_pass[14:0], pass_gate_in};
      h_aux = {h_aux[14:0], aux_signal_in};
      h_av = {h_av[14:0], active_video_in};
      h_sync = {h_sync[14:0], sync_in};
      h_blank = {h_blank[14:0], blank_in};
      h_cb = {h_cb[14:0], ph};
      if (chk_en)
      begin
         check(pass_gate_delayed_out === h_pass[14], "pass delay");
         check(aux_signal_delayed_out === h_aux[14], "aux delay");
         check(delayed_active_video_out === h_av[av_n], "av delay");
         check(sync_current_en === h_sync[conv_n], "sync delay");
         check(blank_current_en === h_blank[conv_n], "blank delay");
         if (!cfg_q[2])
            check(mixed_pixel_out === h_px[14], "pixel out");
         if (cfg_q[2] && h_av[14])
            check(chroma_cb_out === h_cb[14], "cb phase");
      end
   end

   ////////////////////////////////////////////////////////////
   // outputs quiet under reset, then release
   task automatic test_reset();
      repeat (5) @(posedge ref_clk);
      check({host_data_out, host_data_oe, pass_gate_delayed_out, aux_signal_delayed_out,
         delayed_active_video_out, sync_current_en, blank_current_en, mixed_pixel_out,
         chroma_cb_out} === 39'h00_0000_0000, "reset outputs");
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
   endtask

   // one output setting: stream checked, then setting read back
   task automatic test_stream(input logic [7:0] cfg);
      u_mixer_host_model.access(1'b0, 3'h0, cfg, rd, oe);
      cfg_q <= cfg;
      av_n <= cfg[3] ? 12 : 14;
      conv_n <= cfg[4] ? 15 : 2;
      repeat (20) @(posedge ref_clk);
      chk_en <= 1'b1;
      repeat (130) @(posedge ref_clk);
      chk_en <= 1'b0;
      u_mixer_host_model.access(1'b1, 3'h0, 8'h00, rd, oe);
      check(rd === cfg && oe === 1'b1, "ctrl0 readback");
   endtask

   // spare registers, unmapped index, port release
   task automatic test_regs();
      u_mixer_host_model.access(1'b0, 3'h1, 8'hA5, rd, oe);
      u_mixer_host_model.access(1'b0, 3'h2, 8'h3C, rd, oe);
      u_mixer_host_model.access(1'b0, 3'h7, 8'hFF, rd, oe);
      u_mixer_host_model.access(1'b1, 3'h1, 8'h00, rd, oe);
      check(rd === 8'hA5 && oe === 1'b1, "ctrl1 read");
      u_mixer_host_model.access(1'b1, 3'h2, 8'h00, rd, oe);
      check(rd === 8'h3C, "ctrl2 read");
      u_mixer_host_model.access(1'b1, 3'h7, 8'h00, rd, oe);
      check(rd === 8'h00, "unmapped read");
      check(host_data_oe === 1'b0, "port released");
   endtask

   // table buffer overflow, drop flag, drain and read back
   task automatic test_fifo();
      av_force <= 1'b1;
      u_mixer_host_model.access(1'b0, 3'h3, 8'h10, rd, oe);
      for (int i = 0; i < 9; i++)
         u_mixer_host_model.access(1'b0, 3'h4, 8'h30 + 8'(i), rd, oe);
      u_mixer_host_model.access(1'b1, 3'h6, 8'h00, rd, oe);
      check(rd === 8'hC8, "status full drop");
      u_mixer_host_model.access(1'b0, 3'h6, 8'h80, rd, oe);
      u_mixer_host_model.access(1'b1, 3'h6, 8'h00, rd, oe);
      check(rd === 8'h48, "drop cleared");
      av_force <= 1'b0;
      repeat (300) @(posedge ref_clk);
      u_mixer_host_model.access(1'b1, 3'h6, 8'h00, rd, oe);
      check(rd === 8'h00, "buffer drained");
      // alpha entry goes in after the drain, so the buffer has room
      u_mixer_host_model.access(1'b0, 3'h3, 8'h20, rd, oe);
      u_mixer_host_model.access(1'b0, 3'h5, 8'h77, rd, oe);
      repeat (80) @(posedge ref_clk);
      u_mixer_host_model.access(1'b0, 3'h3, 8'h10, rd, oe);
      u_mixer_host_model.access(1'b1, 3'h4, 8'h00, rd, oe);
      check(rd === 8'h30, "colour entry 0");
      u_mixer_host_model.access(1'b1, 3'h4, 8'h00, rd, oe);
      check(rd === 8'h31, "colour entry 1");
      u_mixer_host_model.access(1'b0, 3'h3, 8'h20, rd, oe);
      u_mixer_host_model.access(1'b1, 3'h5, 8'h00, rd, oe);
      check(rd === 8'h77, "alpha entry");
   endtask

   ////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // hang guard
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      test_done();
   end

   // main sequence
   initial
   begin
      test_reset();
      repeat (3) @(posedge ref_clk);
      test_stream(8'h00);
      test_stream(8'h01);
      test_stream(8'h03);
      test_stream(8'h18);
      test_stream(8'h04);
      test_regs();
      test_fifo();
      test_done();
   end
endmodule

`default_nettype wire
